// >>> rtl/sdc_pkg.sv
// constants shared by the serial link diagnostic counter block
package sdc_pkg;
   // ****************************************
   // diagnostic word set layout
   // ****************************************
   localparam int          NUM_WORDS      = 20;
   localparam int          NUM_COUNTERS   = 6;
   localparam int          CAPTURE_WORDS  = 6;
   localparam logic [7:0]  W_ERROR        = 8'h01;
   localparam logic [7:0]  W_CNT_FIRST    = 8'h02;
   localparam logic [7:0]  W_CNT_LAST     = 8'h07;
   localparam logic [7:0]  W_RSVD_LAST    = 8'h0d;
   localparam logic [7:0]  W_VERSION      = 8'h0e;
   localparam logic [7:0]  W_CAP_FIRST    = 8'h0f;
   localparam logic [7:0]  W_LAST         = 8'h14;
   localparam logic [15:0] RSVD_VALUE     = 16'h0000;
   localparam logic [15:0] CNT_RESET      = 16'h0000;
   // counter slots inside a port's counter group
   localparam int          C_SUCCESS      = 0;
   localparam int          C_ERR_REQ      = 1;
   localparam int          C_ABORT        = 2;
   localparam int          C_RETRY        = 3;
   localparam int          C_NAK          = 4;
   localparam int          C_BREAK        = 5;
   localparam logic [1:0]  MAX_RETRIES    = 2'h2;
   // ****************************************
   // local commands and status codes
   // ****************************************
   localparam logic [15:0] CMD_CLEAR      = 16'h1b58;
   localparam logic [15:0] CMD_READ       = 16'h1b59;
   localparam logic [15:0] CMD_CHANGE_ID  = 16'h1b5a;
   localparam logic [15:0] ST_OK          = 16'h0001;
   localparam logic [15:0] ST_BAD_CMD     = 16'h020c;
   localparam logic [15:0] ST_BAD_RANGE   = 16'h040c;
   localparam logic [15:0] ST_BAD_ID      = 16'h050c;
   localparam logic [15:0] ST_NOT_SLAVE   = 16'h060c;
   // arbitrary neutral values
   localparam logic [15:0] FW_VERSION     = 16'h0100;
   localparam logic [63:0] DEFAULT_ID     = 64'h0000_0000_0000_3130;
   typedef enum logic [3:0] {
      SDC_IDLE   = 4'b0001,
      SDC_LOAD   = 4'b0010,
      SDC_STREAM = 4'b0100,
      SDC_FINISH = 4'b1000
   } sdc_state_e;
endpackage : sdc_pkg

// >>> rtl/sdc_capture_mem.sv
// per-port store of the failed request capture, registered read
`timescale 1ns/10ps
`default_nettype none
module sdc_capture_mem #(
   parameter int DEPTH = 2,
   parameter int WIDTH = 96,
   parameter int AW    = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic [AW-1:0]    raddr_i,
   output logic      [WIDTH-1:0] rdata_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   // ****************************************
   // storage
   // ****************************************
   always_ff @(posedge core_clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_o <= '0;
      end
      else
      begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule : sdc_capture_mem
`default_nettype wire

// >>> rtl/sdc_station_id.sv
// changeable station identifier of the slave
`timescale 1ns/10ps
`default_nettype none
module sdc_station_id (
   input  wire logic        core_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        load_i,
   input  wire logic [63:0] id_i,
   output logic      [63:0] station_identifier_o
);
   logic [63:0] next_id;

   // ****************************************
   // identifier register
   // ****************************************
   always_comb
   begin
      next_id = station_identifier_o;
      if (load_i)
      begin
         next_id = {8'h00, id_i[55:0]};
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         station_identifier_o <= sdc_pkg::DEFAULT_ID;
      end
      else
      begin
         station_identifier_o <= next_id;
      end
   end
endmodule : sdc_station_id
`default_nettype wire

// >>> rtl/sdc_diag_counters.sv
// per-port diagnostic word sets, session tracking and local commands
// Function
// - twenty-word set: error, six counters, six reserved, version, six captured words
// - word one keeps latest failure or protocol error code
// - master counts completed requests and keep-alive exchanges as successes
// - slave counts responses, keep-alives and local command completions as successes
// - error-request counter counts non-fatal failures and slave error responses
// - fatal error ends session and counts an abort
// - slave inactivity timeout ends session without counting an abort
// - at most two resends per message, then fatal abort; resends counted
// - fast-access variant counts attach repeats and re-sent requests as retries
// - every negative acknowledgement sent is counted
// - received break is counted and ends any session
// - word fourteen holds firmware version, high and low byte
// - failed request's first six data words overwrite the capture words
// - identifier defaults to built-in value; change command in slave mode only
// - reset restores the default identifier
// - identifier is eight bytes, seven characters and a null
// - identifier whose first character is null is rejected
// - each port keeps its own complete word set
// - clear command zeroes the selected port's words except the version word
// - read command returns count words from a first word
`timescale 1ns/10ps
`default_nettype none
module sdc_diag_counters #(
   parameter int PORTS = 2,
   parameter int PW    = 1
) (
   input  wire logic             core_clk_i,
   input  wire logic             arst_n_i,
   // link engine events, one pulse per event per port
   input  wire logic [PORTS-1:0] ev_success_i,
   input  wire logic [PORTS-1:0] ev_error_req_i,
   input  wire logic [PORTS-1:0] ev_fatal_i,
   input  wire logic [PORTS-1:0] ev_timeout_i,
   input  wire logic [PORTS-1:0] ev_retry_req_i,
   input  wire logic [PORTS-1:0] ev_ack_ok_i,
   input  wire logic [PORTS-1:0] ev_nak_i,
   input  wire logic [PORTS-1:0] ev_break_i,
   input  wire logic [PORTS-1:0] ev_session_start_i,
   // internal protocol error report
   input  wire logic             err_valid_i,
   input  wire logic [PW-1:0]    err_port_i,
   input  wire logic [15:0]      err_code_i,
   // host command request
   input  wire logic             cmd_valid_i,
   input  wire logic [15:0]      cmd_code_i,
   input  wire logic [PW-1:0]    cmd_port_i,
   input  wire logic             cmd_slave_mode_i,
   input  wire logic [7:0]       cmd_first_i,
   input  wire logic [7:0]       cmd_count_i,
   input  wire logic [63:0]      cmd_id_i,
   input  wire logic [95:0]      cmd_block_i,
   output logic                  cmd_ready_o,
   output logic                  cmd_done_o,
   output logic      [15:0]      cmd_status_o,
   output logic                  rd_valid_o,
   output logic      [7:0]       rd_index_o,
   output logic      [15:0]      rd_data_o,
   output logic      [PORTS-1:0] session_active_o,
   output logic      [PORTS-1:0] retry_denied_o,
   output logic      [63:0]      station_identifier_o
);
   // ****************************************
   // command state
   // ****************************************
   sdc_pkg::sdc_state_e state, next_state;
   logic [15:0]         code_q, next_code;
   logic [PW-1:0]       port_q, next_port;
   logic [7:0]          idx_q, next_idx;
   logic [7:0]          left_q, next_left;
   logic [63:0]         id_q, next_id;
   logic [95:0]         block_q, next_block;
   logic [15:0]         status_q, next_status;
   logic                next_ready;
   logic                next_done;
   logic [15:0]         next_cmd_status;
   logic                next_rd_valid;
   logic [7:0]          next_rd_index;
   logic [15:0]         next_rd_data;
   logic [8:0]          last_word;
   logic                fin_ok;
   logic                fin_fail;
   logic                fin_clear;
   logic                id_load;
   logic [95:0]         cap_rdata;
   localparam int NCW = 16 * sdc_pkg::NUM_COUNTERS;
   logic [PORTS-1:0][NCW-1:0] cnt_flat;
   logic [PORTS-1:0][15:0]    err_flat;
   logic [PORTS-1:0]          cap_flag;

   assign fin_ok    = (state == sdc_pkg::SDC_FINISH) && (status_q == sdc_pkg::ST_OK);
   assign fin_fail  = (state == sdc_pkg::SDC_FINISH) && (status_q != sdc_pkg::ST_OK);
   assign fin_clear = fin_ok && (code_q == sdc_pkg::CMD_CLEAR);
   assign id_load   = fin_ok && (code_q == sdc_pkg::CMD_CHANGE_ID);
   assign last_word = {1'b0, cmd_first_i} + {1'b0, cmd_count_i} - 9'h001;

   // ****************************************
   // command sequencer
   // ****************************************
   always_comb
   begin
      next_state  = state;
      next_code   = code_q;
      next_port   = port_q;
      next_idx    = idx_q;
      next_left   = left_q;
      next_id     = id_q;
      next_block  = block_q;
      next_status = status_q;
      next_done   = 1'b0;
      next_cmd_status = cmd_status_o;
      next_rd_valid   = 1'b0;
      next_rd_index   = rd_index_o;
      next_rd_data    = rd_data_o;
      case (state)
         sdc_pkg::SDC_IDLE:
         begin
            if (cmd_valid_i)
            begin
               next_code   = cmd_code_i;
               next_port   = cmd_port_i;
               next_idx    = cmd_first_i;
               next_left   = cmd_count_i;
               next_id     = cmd_id_i;
               next_block  = cmd_block_i;
               next_status = sdc_pkg::ST_OK;
               next_state  = sdc_pkg::SDC_FINISH;
               case (cmd_code_i)
                  sdc_pkg::CMD_CLEAR: next_status = sdc_pkg::ST_OK;
                  // range must sit inside the set
                  sdc_pkg::CMD_READ:
                  begin
                     if (cmd_first_i == 8'h00 || cmd_count_i == 8'h00 ||
                         last_word > {1'b0, sdc_pkg::W_LAST})
                     begin
                        next_status = sdc_pkg::ST_BAD_RANGE;
                     end
                     else
                     begin
                        next_state = sdc_pkg::SDC_LOAD;
                     end
                  end
                  sdc_pkg::CMD_CHANGE_ID:
                  begin
                     if (!cmd_slave_mode_i)
                     begin
                        next_status = sdc_pkg::ST_NOT_SLAVE;
                     end
                     else if (cmd_id_i[7:0] == 8'h00)
                     begin
                        next_status = sdc_pkg::ST_BAD_ID;
                     end
                  end
                  default: next_status = sdc_pkg::ST_BAD_CMD;
               endcase
            end
         end
         // capture memory read takes one cycle
         sdc_pkg::SDC_LOAD: next_state = sdc_pkg::SDC_STREAM;
         sdc_pkg::SDC_STREAM:
         begin
            next_rd_valid = 1'b1;
            next_rd_index = idx_q;
            next_rd_data  = word_of(idx_q);
            next_idx      = idx_q + 8'h01;
            next_left     = left_q - 8'h01;
            if (left_q == 8'h01)
            begin
               next_state = sdc_pkg::SDC_FINISH;
            end
         end
         sdc_pkg::SDC_FINISH:
         begin
            next_done       = 1'b1;
            next_cmd_status = status_q;
            next_state      = sdc_pkg::SDC_IDLE;
         end
         default: next_state = sdc_pkg::SDC_IDLE;
      endcase
      next_ready = (next_state == sdc_pkg::SDC_IDLE);
   end

   // word layout of the selected port
   function automatic logic [15:0] word_of(input logic [7:0] w);
      logic [NCW-1:0] c;
      logic [7:0]     k;
      c = cnt_flat[port_q];
      k = 8'h00;
      word_of = sdc_pkg::RSVD_VALUE;
      if (w == sdc_pkg::W_ERROR)
      begin
         word_of = err_flat[port_q];
      end
      else if (w >= sdc_pkg::W_CNT_FIRST && w <= sdc_pkg::W_CNT_LAST)
      begin
         k = w - sdc_pkg::W_CNT_FIRST;
         word_of = c[k*16 +: 16];
      end
      else if (w == sdc_pkg::W_VERSION)
      begin
         word_of = sdc_pkg::FW_VERSION;
      end
      else if (w >= sdc_pkg::W_CAP_FIRST && cap_flag[port_q])
      begin
         k = w - sdc_pkg::W_CAP_FIRST;
         word_of = cap_rdata[k*16 +: 16];
      end
   endfunction : word_of

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state        <= sdc_pkg::SDC_IDLE;
         code_q       <= 16'h0000;
         port_q       <= '0;
         idx_q        <= 8'h00;
         left_q       <= 8'h00;
         id_q         <= 64'h0;
         block_q      <= 96'h0;
         status_q     <= 16'h0000;
         cmd_ready_o  <= 1'b1;
         cmd_done_o   <= 1'b0;
         cmd_status_o <= 16'h0000;
         rd_valid_o   <= 1'b0;
         rd_index_o   <= 8'h00;
         rd_data_o    <= 16'h0000;
      end
      else
      begin
         state        <= next_state;
         code_q       <= next_code;
         port_q       <= next_port;
         idx_q        <= next_idx;
         left_q       <= next_left;
         id_q         <= next_id;
         block_q      <= next_block;
         status_q     <= next_status;
         cmd_ready_o  <= next_ready;
         cmd_done_o   <= next_done;
         cmd_status_o <= next_cmd_status;
         rd_valid_o   <= next_rd_valid;
         rd_index_o   <= next_rd_index;
         rd_data_o    <= next_rd_data;
      end
   end

   // ****************************************
   // per-port counters and session state
   // ****************************************
   // one full set per port
   for (genvar p = 0; p < PORTS; p++)
   begin : g_port
      logic [NCW-1:0] c_q, next_c;
      logic [15:0]    e_q, next_e;
      logic           cap_q, next_cap;
      logic           sess_q, next_sess;
      logic           deny_q, next_deny;
      logic [1:0]     rc_q, next_rc;
      logic           mine;
      assign mine = (port_q == PW'(p));
      always_comb
      begin
         next_c    = c_q;
         next_e    = e_q;
         next_cap  = cap_q;
         next_sess = sess_q;
         next_deny = 1'b0;
         next_rc   = rc_q;
         if (ev_session_start_i[p])
         begin
            next_sess = 1'b1;
         end
         // link successes plus local completions, wrapping
         next_c[sdc_pkg::C_SUCCESS*16 +: 16] = c_q[sdc_pkg::C_SUCCESS*16 +: 16]
            + {15'h0, ev_success_i[p]} + {15'h0, fin_ok & mine};
         next_c[sdc_pkg::C_ERR_REQ*16 +: 16] = c_q[sdc_pkg::C_ERR_REQ*16 +: 16]
            + {15'h0, ev_error_req_i[p]} + {15'h0, fin_fail & mine};
         next_c[sdc_pkg::C_NAK*16 +: 16] = c_q[sdc_pkg::C_NAK*16 +: 16]
            + {15'h0, ev_nak_i[p]};
         // resend allowed twice, third request is fatal
         if (ev_retry_req_i[p] && rc_q < sdc_pkg::MAX_RETRIES)
         begin
            next_c[sdc_pkg::C_RETRY*16 +: 16] = c_q[sdc_pkg::C_RETRY*16 +: 16] + 16'h0001;
            next_rc = rc_q + 2'h1;
         end
         if (ev_ack_ok_i[p])
         begin
            next_rc = 2'h0;
         end
         next_deny = ev_retry_req_i[p] && (rc_q >= sdc_pkg::MAX_RETRIES);
         // fatal errors and exhausted resends abort
         next_c[sdc_pkg::C_ABORT*16 +: 16] = c_q[sdc_pkg::C_ABORT*16 +: 16]
            + {15'h0, ev_fatal_i[p]} + {15'h0, next_deny};
         if (ev_fatal_i[p] || next_deny)
         begin
            next_sess = 1'b0;
            next_rc   = 2'h0;
         end
         // timeout ends session, no abort counted
         if (ev_timeout_i[p])
         begin
            next_sess = 1'b0;
         end
         next_c[sdc_pkg::C_BREAK*16 +: 16] = c_q[sdc_pkg::C_BREAK*16 +: 16]
            + {15'h0, ev_break_i[p]};
         if (ev_break_i[p])
         begin
            next_sess = 1'b0;
            next_rc   = 2'h0;
         end
         // latest code, command failure wins a tie
         if (err_valid_i && err_port_i == PW'(p))
         begin
            next_e = err_code_i;
         end
         if (fin_fail && mine)
         begin
            next_e   = status_q;
            next_cap = 1'b1;
         end
         // clear drops events of the same cycle
         if (fin_clear && mine)
         begin
            next_c   = '0;
            next_e   = 16'h0000;
            next_cap = 1'b0;
         end
      end
      always_ff @(posedge core_clk_i or negedge arst_n_i)
      begin
         if (!arst_n_i)
         begin
            c_q    <= {sdc_pkg::NUM_COUNTERS{sdc_pkg::CNT_RESET}};
            e_q    <= 16'h0000;
            cap_q  <= 1'b0;
            sess_q <= 1'b0;
            deny_q <= 1'b0;
            rc_q   <= 2'h0;
         end
         else
         begin
            c_q    <= next_c;
            e_q    <= next_e;
            cap_q  <= next_cap;
            sess_q <= next_sess;
            deny_q <= next_deny;
            rc_q   <= next_rc;
         end
      end
      assign cnt_flat[p]         = c_q;
      assign err_flat[p]         = e_q;
      assign cap_flag[p]         = cap_q;
      assign session_active_o[p] = sess_q;
      assign retry_denied_o[p]   = deny_q;
   end

   // ****************************************
   // capture store and identifier
   // ****************************************
   // failed request block overwrites capture
   sdc_capture_mem #(
      .DEPTH (PORTS),
      .WIDTH (16 * sdc_pkg::CAPTURE_WORDS),
      .AW    (PW)
   ) u_cap (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .we_i       (fin_fail),
      .waddr_i    (port_q),
      .wdata_i    (block_q),
      .raddr_i    (port_q),
      .rdata_o    (cap_rdata)
   );

   sdc_station_id u_id (
      .core_clk_i           (core_clk_i),
      .arst_n_i             (arst_n_i),
      .load_i               (id_load),
      .id_i                 (id_q),
      .station_identifier_o (station_identifier_o)
   );
endmodule : sdc_diag_counters
`default_nettype wire

// >>> dv/sdc_diag_checker.sv
// port assertions for the diagnostic counter block
`timescale 1ns/10ps
`default_nettype none
module sdc_diag_checker #(
   parameter int PORTS = 2,
   parameter int PW    = 1
) (
   input wire logic             core_clk_i,
   input wire logic             arst_n_i,
   input wire logic [PORTS-1:0] ev_fatal_i,
   input wire logic [PORTS-1:0] ev_timeout_i,
   input wire logic [PORTS-1:0] ev_break_i,
   input wire logic [PORTS-1:0] ev_session_start_i,
   input wire logic             cmd_valid_i,
   input wire logic [15:0]      cmd_code_i,
   input wire logic             cmd_ready_o,
   input wire logic             cmd_done_o,
   input wire logic [15:0]      cmd_status_o,
   input wire logic             rd_valid_o,
   input wire logic [7:0]       rd_index_o,
   input wire logic [15:0]      rd_data_o,
   input wire logic [PORTS-1:0] session_active_o,
   input wire logic [PORTS-1:0] retry_denied_o,
   input wire logic [63:0]      station_identifier_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic             acc;
   logic [PORTS-1:0] ends;
   assign acc  = cmd_valid_i && cmd_ready_o;
   // an end event with a start in the same cycle is left out, although the end still wins
   assign ends = (ev_fatal_i | ev_timeout_i | ev_break_i) & ~ev_session_start_i;
   short_cmd_a: assert property (
      acc && cmd_code_i != sdc_pkg::CMD_READ |=> !cmd_ready_o ##1 cmd_done_o)
      else $error("short command done not two cycles after accept");
   busy_bound_a: assert property (!cmd_ready_o |-> ##[1:30] cmd_done_o)
      else $error("busy command never completes");
   rd_index_a: assert property (
      rd_valid_o |-> !cmd_ready_o && rd_index_o >= sdc_pkg::W_ERROR
                     && rd_index_o <= sdc_pkg::W_LAST)
      else $error("read word number outside the set");
   rd_step_a: assert property (
      rd_valid_o && $past(rd_valid_o) |-> rd_index_o == $past(rd_index_o) + 8'h01)
      else $error("read words not consecutive");
   rsvd_zero_a: assert property (
      rd_valid_o && rd_index_o > sdc_pkg::W_CNT_LAST && rd_index_o <= sdc_pkg::W_RSVD_LAST
      |-> rd_data_o == sdc_pkg::RSVD_VALUE)
      else $error("reserved word not zero");
   fw_word_a: assert property (
      rd_valid_o && rd_index_o == sdc_pkg::W_VERSION |-> rd_data_o == sdc_pkg::FW_VERSION)
      else $error("version word wrong");
   status_hold_a: assert property (!cmd_done_o |-> $stable(cmd_status_o))
      else $error("status changed without done");
   id_form_a: assert property (
      station_identifier_o[63:56] == 8'h00 && station_identifier_o[7:0] != 8'h00)
      else $error("identifier form broken");
   denied_end_a: assert property (
      |retry_denied_o |-> (retry_denied_o & session_active_o) == '0)
      else $error("session kept after denied retry");
   session_end_a: assert property (
      |ends |=> (session_active_o & $past(ends)) == '0)
      else $error("session kept after end event");
   cover property (acc && cmd_code_i == sdc_pkg::CMD_READ);
   cover property (|retry_denied_o);
   cover property (cmd_done_o && cmd_status_o == sdc_pkg::ST_BAD_ID);
endmodule : sdc_diag_checker
`default_nettype wire

// >>> dv/sdc_link_model.sv
// far side model: link engine event pulses and protocol error reports
`timescale 1ns/10ps
`default_nettype none
module sdc_link_model #(
   parameter int PORTS = 2,
   parameter int PW    = 1
) (
   input  wire logic             core_clk_i,
   output logic      [PORTS-1:0] ev_o [9],
   output logic                  err_valid_o,
   output logic      [PW-1:0]    err_port_o,
   output logic      [15:0]      err_code_o
);
   // kinds: 0 ok 1 err_req 2 fatal 3 timeout 4 retry 5 ack 6 nak 7 break 8 start
   initial
   begin
      ev_o = '{default: '0};
      err_valid_o = 1'b0;
      err_port_o = '0;
      err_code_o = 16'h0000;
   end
   // one-cycle pulses with a gap, so back-to-back calls never merge
   task automatic pulse(input int k, input int p);
      @(posedge core_clk_i);
      ev_o[k][p] <= 1'b1;
      @(posedge core_clk_i);
      ev_o[k] <= '0;
   endtask : pulse
   task automatic open_sess(input int p);
      pulse(7, p);
      pulse(8, p);
   endtask : open_sess
   task automatic err(input int p, input logic [15:0] code);
      @(posedge core_clk_i);
      err_valid_o <= 1'b1;
      err_port_o <= PW'(p);
      err_code_o <= code;
      @(posedge core_clk_i);
      err_valid_o <= 1'b0;
   endtask : err
endmodule : sdc_link_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the diagnostic counter block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b1;
   logic [1:0]  ev [9];
   logic        e_v;
   logic [0:0]  e_p;
   logic [15:0] e_c;
   logic        c_v = 1'b0;
   logic [15:0] c_code = 16'h0000;
   logic [0:0]  c_port = 1'b0;
   logic        c_slv = 1'b0;
   logic [7:0]  c_first = 8'h00;
   logic [7:0]  c_cnt = 8'h00;
   logic [63:0] c_id = 64'h0;
   logic [95:0] c_blk = 96'h0;
   logic        rdy, dn, rdv;
   logic [15:0] st, rdat, st_got;
   logic [7:0]  ridx;
   logic [1:0]  sact, rden;
   logic [63:0] sid;
   logic [15:0] w [1:20];
   logic [15:0] e [1:20];
   logic [15:0] fc [5] = '{16'h1b5b, sdc_pkg::CMD_READ, sdc_pkg::CMD_READ,
                           sdc_pkg::CMD_CHANGE_ID, sdc_pkg::CMD_CHANGE_ID};
   logic [15:0] fe [5] = '{sdc_pkg::ST_BAD_CMD, sdc_pkg::ST_BAD_RANGE, sdc_pkg::ST_BAD_RANGE,
                           sdc_pkg::ST_NOT_SLAVE, sdc_pkg::ST_BAD_ID};
   logic [7:0]  ff [5] = '{8'h01, 8'h00, 8'h14, 8'h01, 8'h01};
   int          err_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   always #2 clk = ~clk;
   sdc_diag_counters u_sdc_diag_counters (
      .core_clk_i(clk), .arst_n_i(rst_n), .ev_success_i(ev[0]), .ev_error_req_i(ev[1]),
      .ev_fatal_i(ev[2]), .ev_timeout_i(ev[3]), .ev_retry_req_i(ev[4]), .ev_ack_ok_i(ev[5]),
      .ev_nak_i(ev[6]), .ev_break_i(ev[7]), .ev_session_start_i(ev[8]), .err_valid_i(e_v),
      .err_port_i(e_p), .err_code_i(e_c), .cmd_valid_i(c_v), .cmd_code_i(c_code),
      .cmd_port_i(c_port), .cmd_slave_mode_i(c_slv), .cmd_first_i(c_first),
      .cmd_count_i(c_cnt), .cmd_id_i(c_id), .cmd_block_i(c_blk), .cmd_ready_o(rdy),
      .cmd_done_o(dn), .cmd_status_o(st), .rd_valid_o(rdv), .rd_index_o(ridx),
      .rd_data_o(rdat), .session_active_o(sact), .retry_denied_o(rden),
      .station_identifier_o(sid));
   sdc_link_model u_sdc_link_model (
      .core_clk_i(clk), .ev_o(ev), .err_valid_o(e_v), .err_port_o(e_p), .err_code_o(e_c));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("checks=%0d mismatches=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task automatic cmd(input logic [15:0] code, input logic [0:0] p, input logic slv,
                      input logic [7:0] f, input logic [7:0] n, input logic [63:0] id,
                      input logic [95:0] blk);
      int k;
      foreach (w[i]) w[i] = 16'hdead;
      @(posedge clk);
      c_v <= 1'b1;
      c_code <= code;
      c_port <= p;
      c_slv <= slv;
      c_first <= f;
      c_cnt <= n;
      c_id <= id;
      c_blk <= blk;
      do @(posedge clk); while (rdy !== 1'b1);
      c_v <= 1'b0;
      k = 0;
      do
      begin
         @(posedge clk);
         if (rdv === 1'b1) w[ridx] = rdat;
         k++;
      end
      while (dn !== 1'b1 && k < 40);
      st_got = st;
      if (k >= 40) err_count++;
   endtask : cmd
   task automatic rd(input logic [0:0] p, input int f, input int n);
      cmd(sdc_pkg::CMD_READ, p, 1'b0, 8'(f), 8'(n), 64'h0, 96'h0);
      chk(st_got, sdc_pkg::ST_OK);
      for (int i = f; i < f + n; i++) chk(w[i], e[i]);
   endtask : rd
   task automatic e_clr;
      foreach (e[i]) e[i] = 16'h0000;
      e[14] = sdc_pkg::FW_VERSION;
   endtask : e_clr
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         results();
      end
   end
   initial
   begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk(sid, sdc_pkg::DEFAULT_ID);
      e_clr();
      rd(1'b0, 1, 20);
      u_sdc_link_model.open_sess(0);
      @(posedge clk) chk(sact, 2'b01);
      for (int i = 0; i < 3; i++) u_sdc_link_model.pulse(0, 0);
      u_sdc_link_model.pulse(1, 0);
      repeat (2) u_sdc_link_model.pulse(6, 0);
      u_sdc_link_model.pulse(5, 0);
      repeat (3) u_sdc_link_model.pulse(4, 0);
      @(posedge clk) chk(rden, 2'b01);
      u_sdc_link_model.open_sess(0);
      u_sdc_link_model.pulse(2, 0);
      u_sdc_link_model.open_sess(0);
      u_sdc_link_model.pulse(3, 0);
      u_sdc_link_model.pulse(0, 1);
      u_sdc_link_model.err(0, 16'h0a05);
      @(posedge clk) chk(sact, 2'b00);
      e = '{16'h0a05, 16'h4, 16'h1, 16'h2, 16'h2, 16'h2, 16'h3, 16'h0, 16'h0, 16'h0,
            16'h0, 16'h0, 16'h0, sdc_pkg::FW_VERSION, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
      rd(1'b0, 1, 20);
      e[2] = 16'h1;
      rd(1'b1, 2, 1);
      for (int i = 0; i < 5; i++)
      begin
         cmd(fc[i], 1'b0, i == 4, ff[i], 8'h02, (i == 3) ? 64'h41 : 64'h0,
             {16'h6, 16'h5, 16'h4, 16'h3, 16'h2, 16'(i)});
         chk(st_got, fe[i]);
      end
      e[1] = sdc_pkg::ST_BAD_ID;
      e[2] = 16'h5;
      e[3] = 16'h6;
      for (int k = 15; k <= 20; k++) e[k] = 16'(k - 14);
      e[15] = 16'h4;
      rd(1'b0, 1, 20);
      cmd(sdc_pkg::CMD_CHANGE_ID, 1'b0, 1'b1, 8'h0, 8'h0, 64'h5a00_3144_4957_454e, 96'h0);
      chk(st_got, sdc_pkg::ST_OK);
      chk(sid, 64'h0000_3144_4957_454e);
      cmd(sdc_pkg::CMD_CLEAR, 1'b0, 1'b0, 8'h0, 8'h0, 64'h0, 96'h0);
      chk(st_got, sdc_pkg::ST_OK);
      e_clr();
      rd(1'b0, 3, 18);
      e[2] = 16'h2;
      rd(1'b1, 2, 1);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(sid, sdc_pkg::DEFAULT_ID);
      rst_n <= 1'b1;
      e_clr();
      rd(1'b1, 1, 20);
      results();
   end
endmodule : testbench
bind sdc_diag_counters sdc_diag_checker #(.PORTS(PORTS), .PW(PW)) u_sdc_diag_checker (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .ev_fatal_i(ev_fatal_i),
   .ev_timeout_i(ev_timeout_i), .ev_break_i(ev_break_i),
   .ev_session_start_i(ev_session_start_i), .cmd_valid_i(cmd_valid_i),
   .cmd_code_i(cmd_code_i), .cmd_ready_o(cmd_ready_o), .cmd_done_o(cmd_done_o),
   .cmd_status_o(cmd_status_o), .rd_valid_o(rd_valid_o), .rd_index_o(rd_index_o),
   .rd_data_o(rd_data_o), .session_active_o(session_active_o),
   .retry_denied_o(retry_denied_o), .station_identifier_o(station_identifier_o));
`default_nettype wire
